/* File: src/rxfc_consts.svh */
// constants of the receive fifo flow controller: offsets, fields, resets, timing
// assumes a 25 mhz system clock and a byte-addressed register bus
`ifndef RXFC_CONSTS_SVH
`define RXFC_CONSTS_SVH

// ============================================================
// register offsets (byte addresses)
`define RXFC_CFG_OFFSET        8'hac
`define RXFC_STATUS_OFFSET     8'hc0

// ============================================================
// configuration register fields
`define RXFC_HI_MSB            23
`define RXFC_HI_LSB            16
`define RXFC_LO_MSB            15
`define RXFC_LO_LSB            8
`define RXFC_DUR_MSB           7
`define RXFC_DUR_LSB           4
`define RXFC_MULT_BIT          3
`define RXFC_BRD_BIT           2
`define RXFC_OWN_BIT           1
`define RXFC_ANY_BIT           0
`define RXFC_CFG_WIDTH         24
`define RXFC_CFG_RESET         24'h000000
`define RXFC_UNIT_ZEROS        6'h00

// ============================================================
// timing
`define RXFC_CLK_PERIOD_NS     40
`define RXFC_NS_PER_US         1000
`define RXFC_JAM_US_0          5
`define RXFC_JAM_US_1          10
`define RXFC_JAM_US_2          15
`define RXFC_JAM_US_3          25
`define RXFC_JAM_STEP_US       50
`define RXFC_JAM_STEP_BASE     3
`define RXFC_JAM_EXTRA_10M_NS  2200
`define RXFC_JAM_CNT_WIDTH     14

`endif

/* File: src/rxfc_pkg.sv */
// types of the receive fifo flow controller
// used together with rxfc_consts.svh
package rxfc_pkg;

    // ============================================================
    // full-duplex pause sequencer
    typedef enum logic [1:0] {
        RXFC_IDLE       = 2'b00,
        RXFC_PAUSE_REQ  = 2'b01,
        RXFC_PAUSED     = 2'b10,
        RXFC_RESUME_REQ = 2'b11
    } rxfc_fd_state_e;

    typedef struct packed {
        logic [23:0]    cfg;
        logic           ack;
        logic [31:0]    readdata;
        rxfc_fd_state_e fd_state;
        logic           pause_zero_time;
    } rxfc_main_s;

    typedef struct packed {
        logic [13:0] count;
    } rxfc_jam_s;

endpackage

/* File: src/rxfc_jam_timer.sv */
// back pressure duration timer for half-duplex jamming
// assumes start is a one-cycle pulse on the system clock
`timescale 1ns/1ps
`include "rxfc_consts.svh"

module rxfc_jam_timer #(
    parameter int unsigned NS_PER_CYCLE = `RXFC_CLK_PERIOD_NS
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       start,
    input  wire logic [3:0] duration_select,
    input  wire logic       speed_100,
    output logic            active
);

    rxfc_pkg::rxfc_jam_s cur;
    rxfc_pkg::rxfc_jam_s next_cur;

    // ============================================================
    // duration in cycles from code and link speed
    function automatic logic [13:0] jam_cycles(input logic [3:0] code, input logic fast);
        int unsigned ns;
        int unsigned cyc;
        case (code)
            4'h0:    ns = `RXFC_JAM_US_0 * `RXFC_NS_PER_US;
            4'h1:    ns = `RXFC_JAM_US_1 * `RXFC_NS_PER_US;
            4'h2:    ns = `RXFC_JAM_US_2 * `RXFC_NS_PER_US;
            4'h3:    ns = `RXFC_JAM_US_3 * `RXFC_NS_PER_US;
            default: ns = (32'(code) - `RXFC_JAM_STEP_BASE) * `RXFC_JAM_STEP_US * `RXFC_NS_PER_US;
        endcase
        if (!fast)
        begin
            ns = ns + `RXFC_JAM_EXTRA_10M_NS;
        end
        cyc = ns / NS_PER_CYCLE;
        if (cyc == 0)
        begin
            cyc = 1;
        end
        jam_cycles = cyc[13:0];
    endfunction

    // ============================================================
    // countdown; a new matching frame restarts the full period
    always_comb
    begin
        next_cur = cur;
        if (start)
        begin
            next_cur.count = jam_cycles(duration_select, speed_100);
        end
        else if (cur.count != 14'h0000)
        begin
            next_cur.count = cur.count - 14'h0001;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign active = (cur.count != 14'h0000);

endmodule

/* File: src/rxfc_flow_ctrl.sv */
// receive fifo flow controller: pause requests and half-duplex back pressure
// assumes mac status inputs share clk; registers reached over avalon-mm
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
`include "rxfc_consts.svh"

// Contract
// - nothing sent while transmitter disabled
// - high mark bits 23:16, 64-byte units
// - full duplex: one pause at high mark
// - half duplex: jam matching frames for duration
// - low mark bits 15:8: zero pause below
// - zero pause only after pause sent
// - zero pause whenever flow control enabled
// - duration ignored in full duplex
// - bit 3 jams multicast frames
// - bit 2 jams broadcast frames
// - bit 1 jams own-address frames
// - bit 0 any frame, enables full duplex
// - any-frame half duplex jams on preamble
// - any-frame full duplex pauses immediately
// - any-frame bit overrides bits 3:1
// - duration codes map to fixed microsecond periods
module rxfc_flow_ctrl #(
    parameter int unsigned JAM_NS_PER_CYCLE = `RXFC_CLK_PERIOD_NS
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // avalon-mm slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // mac and receive path status
    input  wire logic        tx_enabled,
    input  wire logic        full_duplex,
    input  wire logic        speed_100,
    input  wire logic [13:0] rx_fifo_used_bytes,
    input  wire logic        rx_preamble_valid,
    input  wire logic        rx_dest_valid,
    input  wire logic        rx_dest_multicast,
    input  wire logic        rx_dest_broadcast,
    input  wire logic        rx_dest_own,
    // pause request handshake towards the mac transmitter
    output logic             pause_request,
    output logic             pause_zero_time,
    input  wire logic        pause_sent,
    // half-duplex jam
    output logic             backpressure
);

    rxfc_pkg::rxfc_main_s cur;
    rxfc_pkg::rxfc_main_s next_cur;

    logic [7:0] pause_high_threshold;
    logic [7:0] resume_low_threshold;
    logic [3:0] jam_duration_select;
    logic       jam_on_multicast;
    logic       jam_on_broadcast;
    logic       jam_on_own_address;
    logic       flow_on_any_frame;
    logic       flow_enabled;
    logic       high_reached;
    logic       below_low;
    logic       frame_match;
    logic       jam_start;
    logic       jam_active;
    logic       bus_req;

    // ============================================================
    // helpers

    // fifo level compared with a threshold in 64-byte units
    function automatic logic level_reached(input logic [13:0] used, input logic [7:0] field);
        level_reached = (used >= {field, `RXFC_UNIT_ZEROS});
    endfunction

    // byte-lane merge of a write into the writable configuration bits
    function automatic logic [23:0] lane_merge(
        input logic [23:0] old,
        input logic [31:0] wdata,
        input logic [3:0]  be
    );
        logic [23:0] res;
        res = old;
        if (be[0])
        begin
            res[7:0] = wdata[7:0];
        end
        if (be[1])
        begin
            res[15:8] = wdata[15:8];
        end
        if (be[2])
        begin
            res[23:16] = wdata[23:16];
        end
        lane_merge = res;
    endfunction

    // ============================================================
    // configuration fields
    assign pause_high_threshold = cur.cfg[`RXFC_HI_MSB:`RXFC_HI_LSB];
    assign resume_low_threshold = cur.cfg[`RXFC_LO_MSB:`RXFC_LO_LSB];
    assign jam_duration_select  = cur.cfg[`RXFC_DUR_MSB:`RXFC_DUR_LSB];
    assign jam_on_multicast     = cur.cfg[`RXFC_MULT_BIT];
    assign jam_on_broadcast     = cur.cfg[`RXFC_BRD_BIT];
    assign jam_on_own_address   = cur.cfg[`RXFC_OWN_BIT];
    assign flow_on_any_frame    = cur.cfg[`RXFC_ANY_BIT];
    assign flow_enabled         = |cur.cfg[`RXFC_MULT_BIT:`RXFC_ANY_BIT];

    // ============================================================
    // threshold state, evaluated every cycle
    assign high_reached = level_reached(rx_fifo_used_bytes, pause_high_threshold);
    assign below_low    = !level_reached(rx_fifo_used_bytes, resume_low_threshold);

    // ============================================================
    // half-duplex frame selection
    always_comb
    begin
        if (flow_on_any_frame)
        begin
            // no address decode: the preamble of the next frame triggers
            frame_match = rx_preamble_valid;
        end
        else
        begin
            frame_match = rx_dest_valid &&
                          ((jam_on_multicast && rx_dest_multicast) ||
                           (jam_on_broadcast && rx_dest_broadcast) ||
                           (jam_on_own_address && rx_dest_own));
        end
    end

    // selection bits only act in half duplex; never while tx is off
    assign jam_start = !full_duplex && tx_enabled && high_reached && frame_match;

    rxfc_jam_timer #(
        .NS_PER_CYCLE    (JAM_NS_PER_CYCLE)
    ) u_jam_timer (
        .clk             (clk),
        .sys_rst         (sys_rst),
        .start           (jam_start),
        .duration_select (jam_duration_select),
        .speed_100       (speed_100),
        .active          (jam_active)
    );

    // ============================================================
    // register bus: one wait cycle per access
    assign bus_req = avs_read || avs_write;

    always_comb
    begin
        next_cur = cur;

        // ------------------------------------------------------------
        // avalon slave
        next_cur.ack = bus_req && !cur.ack;
        if (avs_read && !cur.ack)
        begin
            case (avs_address)
                `RXFC_CFG_OFFSET:
                begin
                    next_cur.readdata = {8'h00, cur.cfg};
                end
                `RXFC_STATUS_OFFSET:
                begin
                    next_cur.readdata = {2'b00, rx_fifo_used_bytes, 8'h00, 2'b00,
                                         cur.fd_state, jam_active,
                                         (cur.fd_state == rxfc_pkg::RXFC_PAUSED),
                                         below_low, high_reached};
                end
                default:
                begin
                    next_cur.readdata = 32'h00000000;
                end
            endcase
        end
        if (avs_write && cur.ack && (avs_address == `RXFC_CFG_OFFSET))
        begin
            next_cur.cfg = lane_merge(cur.cfg, avs_writedata, avs_byteenable);
        end

        // ------------------------------------------------------------
        // full-duplex pause sequencer; duration field plays no part here
        case (cur.fd_state)
            rxfc_pkg::RXFC_IDLE:
            begin
                // only the any-frame bit enables full-duplex flow control
                if (full_duplex && flow_on_any_frame && tx_enabled && high_reached)
                begin
                    next_cur.fd_state = rxfc_pkg::RXFC_PAUSE_REQ;
                end
            end
            rxfc_pkg::RXFC_PAUSE_REQ:
            begin
                if (!full_duplex || !flow_on_any_frame)
                begin
                    next_cur.fd_state = rxfc_pkg::RXFC_IDLE;
                end
                else if (tx_enabled && pause_sent)
                begin
                    // a single pause per high crossing
                    next_cur.fd_state = rxfc_pkg::RXFC_PAUSED;
                end
            end
            rxfc_pkg::RXFC_PAUSED:
            begin
                if (!full_duplex)
                begin
                    next_cur.fd_state = rxfc_pkg::RXFC_IDLE;
                end
                else if (flow_enabled && tx_enabled && below_low)
                begin
                    next_cur.fd_state = rxfc_pkg::RXFC_RESUME_REQ;
                end
            end
            rxfc_pkg::RXFC_RESUME_REQ:
            begin
                if (!full_duplex)
                begin
                    next_cur.fd_state = rxfc_pkg::RXFC_IDLE;
                end
                else if (tx_enabled && pause_sent)
                begin
                    next_cur.fd_state = rxfc_pkg::RXFC_IDLE;
                end
            end
            default:
            begin
                next_cur.fd_state = rxfc_pkg::RXFC_IDLE;
            end
        endcase

        next_cur.pause_zero_time = (next_cur.fd_state == rxfc_pkg::RXFC_RESUME_REQ);
    end

    // ============================================================
    // state register
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cur.cfg             <= `RXFC_CFG_RESET;
            cur.ack             <= 1'b0;
            cur.readdata        <= 32'h00000000;
            cur.fd_state        <= rxfc_pkg::RXFC_IDLE;
            cur.pause_zero_time <= 1'b0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // ============================================================
    // outputs
    assign avs_readdata    = cur.readdata;
    assign avs_waitrequest = bus_req && !cur.ack;
    assign pause_zero_time = cur.pause_zero_time;

    // requests are withheld while the transmitter is disabled
    assign pause_request = tx_enabled && ((cur.fd_state == rxfc_pkg::RXFC_PAUSE_REQ) ||
                                          (cur.fd_state == rxfc_pkg::RXFC_RESUME_REQ));
    assign backpressure  = tx_enabled && !full_duplex && jam_active;

endmodule

/* File: verification/rxfc_flow_ctrl_monitor.sv */
// checker for the flow controller: bus wait state, pause sequencing and jam start
// bound to rxfc_flow_ctrl; sees only its ports
`timescale 1ns/1ps
module rxfc_flow_ctrl_monitor (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic        avs_waitrequest,
    input wire logic        tx_enabled,
    input wire logic        full_duplex,
    input wire logic [13:0] rx_fifo_used_bytes,
    input wire logic        rx_preamble_valid,
    input wire logic        rx_dest_valid,
    input wire logic        rx_dest_multicast,
    input wire logic        rx_dest_broadcast,
    input wire logic        rx_dest_own,
    input wire logic        pause_request,
    input wire logic        pause_zero_time,
    input wire logic        pause_sent,
    input wire logic        backpressure
);
    logic [23:0] cfg;
    logic        sent_nz;
    logic        hi_hit;
    logic        sel_hit;
    logic [13:0] lo_lvl;
    assign hi_hit  = rx_fifo_used_bytes >= {cfg[23:16], 6'h00};
    assign lo_lvl  = {cfg[15:8], 6'h00};
    assign sel_hit = |({rx_dest_multicast, rx_dest_broadcast, rx_dest_own} & cfg[3:1]);
    // ============================================================
    // shadow of the configuration and of the last pause sent
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cfg     <= 24'h000000;
            sent_nz <= 1'b0;
        end
        else
        begin
            if (avs_write && !avs_waitrequest && avs_address == 8'hac)
                for (int i = 0; i < 3; i++)
                    if (avs_byteenable[i])
                        cfg[i*8 +: 8] <= avs_writedata[i*8 +: 8];
            if (pause_sent && pause_request)
                sent_nz <= !pause_zero_time;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ============================================================
    // properties
    a_txoff_quiet: assert property (!tx_enabled |-> !pause_request && !backpressure)
        else $error("output active with transmitter off");
    a_fd_no_jam: assert property (full_duplex |-> !backpressure)
        else $error("back pressure in full duplex");
    a_any_jam: assert property (rx_preamble_valid && cfg[0] && hi_hit && tx_enabled && !full_duplex
        |=> backpressure || full_duplex || !tx_enabled)
        else $error("no jam after preamble");
    a_sel_jam: assert property (rx_dest_valid && !cfg[0] && sel_hit && hi_hit && tx_enabled
        && !full_duplex |=> backpressure || full_duplex || !tx_enabled)
        else $error("no jam after matching frame");
    a_pause_start: assert property (full_duplex && cfg[0] && hi_hit && tx_enabled && !pause_request
        && !sent_nz |=> pause_request || !tx_enabled || !full_duplex)
        else $error("no pause at high level");
    a_pause_held: assert property (pause_request && !pause_sent
        |=> pause_request || !tx_enabled || !full_duplex || $changed(cfg))
        else $error("pause request dropped");
    a_zero_after: assert property (pause_request && pause_zero_time |-> sent_nz)
        else $error("zero pause without earlier pause");
    a_one_pause: assert property (pause_request && !pause_zero_time |-> !sent_nz)
        else $error("second pause before zero pause");
    a_zero_low: assert property ($rose(pause_zero_time)
        |-> $past(rx_fifo_used_bytes) < $past(lo_lvl))
        else $error("zero pause above low level");
    a_bus_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus wait longer than one cycle");
endmodule

bind rxfc_flow_ctrl rxfc_flow_ctrl_monitor u_mon (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
    .tx_enabled(tx_enabled), .full_duplex(full_duplex), .rx_fifo_used_bytes(rx_fifo_used_bytes),
    .rx_preamble_valid(rx_preamble_valid), .rx_dest_valid(rx_dest_valid), .rx_dest_multicast(rx_dest_multicast),
    .rx_dest_broadcast(rx_dest_broadcast), .rx_dest_own(rx_dest_own), .pause_request(pause_request),
    .pause_zero_time(pause_zero_time), .pause_sent(pause_sent), .backpressure(backpressure)
);

/* File: verification/rxfc_link_partner.sv */
// transmit side model: sends each requested pause frame after a short or long wait
// assumes pause_request is held until pause_sent
`timescale 1ns/1ps
module rxfc_link_partner (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic pause_request,
    input wire logic slow,
    output logic     pause_sent
);
    logic [4:0] wait_cnt;
    always_ff @(posedge clk)
    begin
        if (sys_rst || !pause_request || pause_sent)
        begin
            wait_cnt   <= 5'h00;
            pause_sent <= 1'b0;
        end
        else
        begin
            wait_cnt   <= wait_cnt + 5'h01;
            pause_sent <= wait_cnt == (slow ? 5'h13 : 5'h01);
        end
    end
endmodule

/* File: verification/rxfc_flow_ctrl_tb.sv */
// self-checking bench for the flow controller: registers, pause frames, jam lengths
// drives the receive status itself; rxfc_link_partner answers pause requests
`timescale 1ns/1ps
module rxfc_flow_ctrl_tb;
    logic        clk, sys_rst, avs_read, avs_write, avs_waitrequest, tx_enabled, full_duplex, speed_100, slow;
    logic        rx_preamble_valid, rx_dest_valid, rx_dest_multicast, rx_dest_broadcast, rx_dest_own;
    logic        pause_request, pause_zero_time, pause_sent, backpressure, s, f, t, h;
    logic [3:0]  avs_byteenable, c;
    logic [7:0]  avs_address;
    logic [13:0] rx_fifo_used_bytes;
    logic [31:0] avs_writedata, avs_readdata, d;
    logic [31:0] exp_rd[$];
    logic        exp_pz[$];
    int          exp_jam[$];
    int          n_errors = 0, compares = 0, run = 0, k, j;

    rxfc_flow_ctrl #(.JAM_NS_PER_CYCLE(4000)) DUT (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tx_enabled(tx_enabled),
        .full_duplex(full_duplex), .speed_100(speed_100), .rx_fifo_used_bytes(rx_fifo_used_bytes),
        .rx_preamble_valid(rx_preamble_valid), .rx_dest_valid(rx_dest_valid), .rx_dest_multicast(rx_dest_multicast),
        .rx_dest_broadcast(rx_dest_broadcast), .rx_dest_own(rx_dest_own), .pause_request(pause_request),
        .pause_zero_time(pause_zero_time), .pause_sent(pause_sent), .backpressure(backpressure));
    rxfc_link_partner u_partner (.clk(clk), .sys_rst(sys_rst), .pause_request(pause_request), .slow(slow),
        .pause_sent(pause_sent));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] be);
        int n;
        n = 0;
        avs_address    <= a;
        avs_write      <= wr;
        avs_read       <= !wr;
        avs_writedata  <= wd;
        avs_byteenable <= be;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
        if (n >= 20)
        begin
            n_errors++;
            report_and_stop();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_rd.push_back(e);
        bus(1'b0, a, 32'h0, 4'hf);
    endtask
    function automatic int jam_cycles(input logic [3:0] code, input logic s100);
        int ns;
        ns = code == 4'h0 ? 5000 : code == 4'h1 ? 10000 : code == 4'h2 ? 15000 : code == 4'h3 ? 25000
            : (int'(code) - 3) * 50000;
        ns += s100 ? 0 : 2200;
        return ns < 8000 ? 1 : ns / 4000;
    endfunction

    // ============================================================
    // result watcher
    always @(posedge clk)
    begin
        if (avs_read && avs_waitrequest === 1'b0)
            check("readdata", avs_readdata, exp_rd.size() ? exp_rd.pop_front() : 'x);
        if (pause_sent && pause_request)
            check("pause zero", pause_zero_time, exp_pz.size() ? exp_pz.pop_front() : 1'bx);
        if (backpressure === 1'b1)
            run++;
        else if (run > 0)
        begin
            check("jam cycles", run, exp_jam.size() ? exp_jam.pop_front() : -1);
            run = 0;
        end
    end

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial
    begin
        {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable, tx_enabled, full_duplex, speed_100, slow,
            rx_preamble_valid, rx_dest_valid, rx_dest_multicast, rx_dest_broadcast, rx_dest_own} = '0;
        rx_fifo_used_bytes = 14'h0000;
        sys_rst = 1'b1;
        void'($urandom(32'hd3c19f1f));
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rd(8'hac, 32'h0);
        rd(8'hc0, 32'h00000001);
        rd(8'h10, 32'h0);
        bus(1'b1, 8'hac, 32'hffffffff, 4'hf);
        rd(8'hac, 32'h00ffffff);
        d = $urandom();
        bus(1'b1, 8'hac, d, 4'h2);
        rd(8'hac, {16'h00ff, d[15:8], 8'hff});
        $display("registers done");
        bus(1'b1, 8'hac, 32'h00040201, 4'hf);
        tx_enabled  <= 1'b1;
        full_duplex <= 1'b1;
        for (int r = 0; r < 2; r++)
        begin
            slow <= r == 0;
            rx_fifo_used_bytes <= 14'h0000;
            repeat (20) @(posedge clk);
            rx_fifo_used_bytes <= 14'h00ff;
            repeat (20) @(posedge clk);
            exp_pz.push_back(1'b0);
            rx_fifo_used_bytes <= 14'h0100;
            repeat (3) @(posedge clk);
            tx_enabled <= 1'b0;
            repeat (6) @(posedge clk);
            tx_enabled <= 1'b1;
            repeat (60) @(posedge clk);
            rx_fifo_used_bytes <= 14'h0080;
            rd(8'hc0, 32'h00800024);
            repeat (20) @(posedge clk);
            exp_pz.push_back(1'b1);
            rx_fifo_used_bytes <= 14'h007f;
            repeat (40) @(posedge clk);
        end
        $display("pause done");
        for (int i = 0; i < 32; i++)
        begin
            k = $urandom_range(3);
            j = $urandom_range(3, 1);
            c = 4'(i);
            s = 1'($urandom_range(1));
            f = k != 0 && $urandom_range(1) != 0;
            t = $urandom_range(3) != 0;
            h = $urandom_range(3) != 0;
            bus(1'b1, 8'hac, {16'h0402, c, k == 0 ? 4'hf : 4'(1 << k)}, 4'hf);
            speed_100   <= s;
            full_duplex <= f;
            tx_enabled  <= t;
            rx_fifo_used_bytes <= h ? 14'h0100 + 14'($urandom_range(99)) : 14'h00ff;
            {rx_dest_multicast, rx_dest_broadcast, rx_dest_own} <= 3'(1 << (j - 1));
            @(posedge clk);
            rx_preamble_valid <= k == 0;
            rx_dest_valid     <= k != 0;
            if (h && t && !f && (k == 0 || j == k))
                exp_jam.push_back(jam_cycles(c, s));
            @(posedge clk);
            rx_preamble_valid <= 1'b0;
            rx_dest_valid     <= 1'b0;
            repeat (160) @(posedge clk);
        end
        $display("jam done");
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rd(8'hac, 32'h0);
        rd(8'hc0, {2'b00, rx_fifo_used_bytes, 16'h0001});
        $display("reset done");
        check("notes left", exp_rd.size() + exp_pz.size() + exp_jam.size(), 0);
        report_and_stop();
    end
endmodule
